// ==== smc_cycle_checker.sv ====
`timescale 1ns/1ns
module smc_cycle_checker (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic cpu_request_in,
  input wire logic host_request_in,
  input wire logic dma_request_in,
  input wire logic refresh_request_in,
  input wire logic host_memw_in,
  input wire logic host_iow_in,
  input wire logic [9:0] host_io_addr_in,
  input wire logic host_addr0_in,
  input wire logic local_bus_write_flag_in,
  input wire logic nvram_select_in,
  input wire logic addr_decode_invalid_in,
  input wire logic [23:0] local_bus_addr_in,
  input wire logic [15:0] local_bus_data_in,
  input wire smc_pkg::smc_dram_word_t dram_rdata_in,
  input wire logic nvram_ready_in,
  output logic [1:0] grant_out,
  output logic cycle_timing_pulse_out,
  output logic row_address_select_out,
  output logic bus_ready_strobe_out,
  output logic memory_done_out,
  output logic io_latch_strobe_out,
  output logic host_lower_lane_enable_out,
  output logic host_upper_lane_enable_out,
  output logic host_transceiver_direction_out,
  output logic lower_write_pulse_out,
  output logic upper_write_pulse_out,
  output logic lower_byte_write_enable_out,
  output logic upper_byte_write_enable_out,
  output logic nvram_write_strobe_out,
  output smc_pkg::smc_dram_word_t dram_wdata_out,
  output logic [15:0] local_bus_read_data_out,
  output smc_pkg::smc_par_status_t parity_check_out,
  output logic cpu_parity_interrupt_out,
  output logic [23:0] fault_address_capture_out,
  output smc_pkg::smc_par_status_t fault_status_capture_out,
  output logic iochrdy_out,
  output logic iochchk_out,
  output logic address_outside_map_out,
  output logic out_of_range_flag_out,
  output logic range_fault_interrupt_out,
  output logic nv_gate_armed_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [smc_pkg::SY_W-1:0] pin_w, s1_q, s2_q, s3_q, flt_q, prev_q, rise_w;

  assign pin_w = {nvram_ready_in, host_iow_in, host_memw_in,
                  refresh_request_in, dma_request_in, host_request_in,
                  cpu_request_in};

  genvar gi;
  generate
    for (gi = 0; gi < smc_pkg::SY_W; gi++) begin : g_sync
      always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          flt_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pin_w[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            flt_q[gi] <= s3_q[gi];
          end
          prev_q[gi] <= flt_q[gi];
        end
      end
      assign rise_w[gi] = flt_q[gi] & ~prev_q[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_win(input logic [4:0] c,
                                  input logic [4:0] lo,
                                  input logic [4:0] hi);
    in_win = (c >= lo) && (c < hi);
  endfunction

  function automatic logic [2:0] pick(input logic [3:0] p,
                                      input smc_pkg::smc_src_t last,
                                      input logic urgent);
    logic [3:0] m;
    m = p;
    pick = 3'h0;
    if (p != (4'h1 << last)) begin
      m[last] = 1'b0;
    end
    if (urgent && p[smc_pkg::SY_REF]) begin
      pick = {1'b1, smc_pkg::SRC_REF};
    end else if (m[smc_pkg::SY_CPU]) begin
      pick = {1'b1, smc_pkg::SRC_CPU};
    end else if (m[smc_pkg::SY_HOST]) begin
      pick = {1'b1, smc_pkg::SRC_HOST};
    end else if (m[smc_pkg::SY_DMA]) begin
      pick = {1'b1, smc_pkg::SRC_DMA};
    end else if (m[smc_pkg::SY_REF]) begin
      pick = {1'b1, smc_pkg::SRC_REF};
    end
  endfunction

  // ----------------------------------------------------------------
  // Cycle control
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_RUN} smc_state_t;

  smc_state_t st_q, st_d;
  smc_pkg::smc_src_t gnt_q, gnt_d;
  logic [4:0] cnt_q, cnt_d;
  logic [3:0] pend_q, pend_d;
  logic [9:0] refw_q, refw_d;
  logic wr_q, wr_d, nv_q, nv_d, a0_q, a0_d;
  logic [23:0] addr_q, addr_d;
  logic bd_raw_q, bd_sync_q, bd_old_q, gate_q, gate_d;
  logic perr_pend_q, perr_pend_d, herr_q, herr_d, address_outside_map_q, address_outside_map_d;
  logic run_d, is_host, dram_rd, err_w, smp_w;
  logic [2:0] pk;
  smc_pkg::smc_par_status_t chk_w, fstat_d;
  logic [23:0] faddr_d;
  logic cpu_int_d, oor_d, rint_d;

  assign is_host = (gnt_q == smc_pkg::SRC_HOST);
  assign dram_rd = (st_q == ST_RUN) && !wr_q && !nv_q
                   && (gnt_q != smc_pkg::SRC_REF);
  assign chk_w.ok_hi = ~^{dram_rdata_in.par_hi, dram_rdata_in.hi};
  assign chk_w.ok_lo = ~^{dram_rdata_in.par_lo, dram_rdata_in.lo};
  assign err_w = ~(chk_w.ok_hi & chk_w.ok_lo);
  assign smp_w = dram_rd && (cnt_q == smc_pkg::C_LATCH);

  always_comb begin
    st_d = st_q;
    gnt_d = gnt_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    nv_d = nv_q;
    a0_d = a0_q;
    addr_d = addr_q;
    pend_d = pend_q;
    refw_d = refw_q;
    gate_d = gate_q;
    perr_pend_d = perr_pend_q;
    herr_d = herr_q;
    address_outside_map_d = address_outside_map_q;
    faddr_d = fault_address_capture_out;
    fstat_d = fault_status_capture_out;
    cpu_int_d = 1'b0;
    pk = pick(pend_q, gnt_q, refw_q >= smc_pkg::C_REF_URGENT);
    // Clears first, so that a new request in the same cycle wins
    if (memory_done_out && gnt_q == smc_pkg::SRC_CPU) begin
      pend_d[smc_pkg::SY_CPU] = 1'b0;
    end
    if (memory_done_out && is_host) begin
      pend_d[smc_pkg::SY_HOST] = 1'b0;
      gate_d = 1'b0;
    end
    if (bd_sync_q && !bd_old_q && gnt_q == smc_pkg::SRC_DMA) begin
      pend_d[smc_pkg::SY_DMA] = 1'b0;
    end
    if (st_q == ST_IDLE && pk[2]) begin
      st_d = ST_RUN;
      gnt_d = smc_pkg::smc_src_t'(pk[1:0]);
      cnt_d = 5'h00;
      wr_d = local_bus_write_flag_in;
      nv_d = nvram_select_in;
      a0_d = host_addr0_in;
      addr_d = local_bus_addr_in;
      if (pk[1:0] == smc_pkg::SRC_REF) begin
        pend_d[smc_pkg::SY_REF] = 1'b0;
        refw_d = 10'h000;
      end
    end else if (st_q == ST_RUN) begin
      cnt_d = cnt_q + 5'h01;
      if (cnt_q == smc_pkg::C_END) begin
        st_d = ST_IDLE;
        perr_pend_d = 1'b0;
      end
    end
    if (pend_q[smc_pkg::SY_REF] && refw_q < smc_pkg::C_REF_URGENT) begin
      refw_d = refw_q + 10'h001;
    end
    pend_d = pend_d | rise_w[3:0];
    if (rise_w[smc_pkg::SY_IOW] && host_io_addr_in == smc_pkg::NV_GATE_PORT)
    begin
      gate_d = 1'b1;
    end
    if (smp_w && err_w && gnt_q == smc_pkg::SRC_CPU) begin
      cpu_int_d = 1'b1;
      faddr_d = addr_q;
      fstat_d = chk_w;
    end
    if (smp_w && err_w && is_host) begin
      perr_pend_d = 1'b1;
    end
    if (rise_w[smc_pkg::SY_MEMW]) begin
      herr_d = 1'b0;
    end
    if (perr_pend_q && cnt_q == smc_pkg::C_HOST_ERR) begin
      herr_d = 1'b1;
    end
    if (st_q == ST_RUN && cnt_q == smc_pkg::C_READY) begin
      address_outside_map_d = 1'b0;
    end
    if (st_q == ST_RUN && cnt_q == smc_pkg::C_SIXTY
        && addr_decode_invalid_in) begin
      address_outside_map_d = 1'b1;
    end
    oor_d = address_outside_map_q;
    rint_d = address_outside_map_q && gnt_q != smc_pkg::SRC_REF;
    run_d = (st_d == ST_RUN);
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= ST_IDLE;
      gnt_q <= smc_pkg::SRC_CPU;
      cnt_q <= 5'h00;
      wr_q <= 1'b0;
      nv_q <= 1'b0;
      a0_q <= 1'b0;
      addr_q <= 24'h000000;
      pend_q <= 4'h0;
      refw_q <= 10'h000;
      gate_q <= 1'b0;
      perr_pend_q <= 1'b0;
      herr_q <= 1'b0;
      address_outside_map_q <= 1'b0;
      bd_raw_q <= 1'b0;
      bd_sync_q <= 1'b0;
      bd_old_q <= 1'b0;
      grant_out <= 2'h0;
      cycle_timing_pulse_out <= 1'b0;
      row_address_select_out <= 1'b0;
      bus_ready_strobe_out <= 1'b0;
      memory_done_out <= 1'b0;
      io_latch_strobe_out <= 1'b0;
      host_lower_lane_enable_out <= 1'b0;
      host_upper_lane_enable_out <= 1'b0;
      host_transceiver_direction_out <= 1'b0;
      lower_write_pulse_out <= 1'b0;
      upper_write_pulse_out <= 1'b0;
      lower_byte_write_enable_out <= 1'b0;
      upper_byte_write_enable_out <= 1'b0;
      nvram_write_strobe_out <= 1'b0;
      dram_wdata_out <= '0;
      local_bus_read_data_out <= 16'h0000;
      parity_check_out <= '0;
      cpu_parity_interrupt_out <= 1'b0;
      fault_address_capture_out <= 24'h000000;
      fault_status_capture_out <= '0;
      iochrdy_out <= smc_pkg::IOCHRDY_RST;
      iochchk_out <= 1'b0;
      address_outside_map_out <= 1'b0;
      out_of_range_flag_out <= 1'b0;
      range_fault_interrupt_out <= 1'b0;
      nv_gate_armed_out <= 1'b0;
    end else begin
      st_q <= st_d;
      gnt_q <= gnt_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      nv_q <= nv_d;
      a0_q <= a0_d;
      addr_q <= addr_d;
      pend_q <= pend_d;
      refw_q <= refw_d;
      gate_q <= gate_d;
      perr_pend_q <= perr_pend_d;
      herr_q <= herr_d;
      address_outside_map_q <= address_outside_map_d;
      bd_raw_q <= bus_ready_strobe_out;
      bd_sync_q <= bd_raw_q;
      bd_old_q <= bd_sync_q;
      memory_done_out <= bd_sync_q & ~bd_old_q;
      grant_out <= gnt_d;
      cycle_timing_pulse_out <= run_d && cnt_d < smc_pkg::C_READY;
      row_address_select_out <= run_d && cnt_d < smc_pkg::C_COL;
      bus_ready_strobe_out <= run_d
        && in_win(cnt_d, smc_pkg::C_READY, smc_pkg::C_END);
      io_latch_strobe_out <= run_d && gnt_d == smc_pkg::SRC_DMA
        && in_win(cnt_d, smc_pkg::C_LATCH, smc_pkg::C_LATCH_END);
      host_lower_lane_enable_out <= run_d && gnt_d == smc_pkg::SRC_HOST
        && !a0_d;
      host_upper_lane_enable_out <= run_d && gnt_d == smc_pkg::SRC_HOST
        && a0_d;
      host_transceiver_direction_out <= run_d
        && gnt_d == smc_pkg::SRC_HOST && !wr_d;
      lower_write_pulse_out <= run_d && wr_d && !nv_d
        && in_win(cnt_d, smc_pkg::C_COL, smc_pkg::C_READY)
        && !(gnt_d == smc_pkg::SRC_HOST && a0_d);
      upper_write_pulse_out <= run_d && wr_d && !nv_d
        && in_win(cnt_d, smc_pkg::C_COL, smc_pkg::C_READY)
        && !(gnt_d == smc_pkg::SRC_HOST && !a0_d);
      lower_byte_write_enable_out <= run_d && !wr_d && !nv_d
        && gnt_d != smc_pkg::SRC_REF;
      upper_byte_write_enable_out <= run_d && !wr_d && !nv_d
        && gnt_d != smc_pkg::SRC_REF;
      nvram_write_strobe_out <= run_d && wr_d && nv_d
        && (gnt_d == smc_pkg::SRC_CPU
            || (gnt_d == smc_pkg::SRC_HOST && gate_d))
        && in_win(cnt_d, smc_pkg::C_SIXTY, smc_pkg::C_READY);
      dram_wdata_out <= {^local_bus_data_in[15:8],
                         local_bus_data_in[15:8],
                         ^local_bus_data_in[7:0], local_bus_data_in[7:0]};
      // Ready line of the memory is passed through so software can poll it
      local_bus_read_data_out <= nv_q
        ? {flt_q[smc_pkg::SY_NVRDY], 7'h00, local_bus_data_in[7:0]}
        : {dram_rdata_in.hi, dram_rdata_in.lo};
      parity_check_out <= chk_w;
      cpu_parity_interrupt_out <= cpu_int_d;
      fault_address_capture_out <= faddr_d;
      fault_status_capture_out <= fstat_d;
      iochrdy_out <= ~pend_d[smc_pkg::SY_HOST];
      iochchk_out <= herr_d;
      address_outside_map_out <= address_outside_map_d;
      out_of_range_flag_out <= oor_d;
      range_fault_interrupt_out <= rint_d;
      nv_gate_armed_out <= gate_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  lane_select_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    host_upper_lane_enable_out |-> a0_q && !host_lower_lane_enable_out)
    else $error("upper lane without odd host address");
  byte_mask_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (lower_write_pulse_out && upper_write_pulse_out) |-> !is_host)
    else $error("host write pulsed both bytes");
  ready_time_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $rose(bus_ready_strobe_out) |-> cnt_q == smc_pkg::C_READY
    && !cycle_timing_pulse_out)
    else $error("bus ready not at 135ns");
  done_after_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $rose(bus_ready_strobe_out) |-> ##3 memory_done_out)
    else $error("memory done missing after bus ready");
  ready_low_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $fell(bus_ready_strobe_out) |-> cnt_q == smc_pkg::C_END)
    else $error("bus ready not dropped at 225ns");
  host_ready_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (memory_done_out && is_host && !rise_w[1]) |=> iochrdy_out)
    else $error("IOCHRDY not raised at host done");
  range_next_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $rose(address_outside_map_out) |=> out_of_range_flag_out)
    else $error("range flag not one clock after invalid");
  refresh_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (gnt_q == smc_pkg::SRC_REF && st_q == ST_RUN && cnt_q > 5'h01)
    |-> !range_fault_interrupt_out)
    else $error("range interrupt in refresh cycle");

endmodule

// ==== smc_mem_model.sv ====
`timescale 1ns/1ns
module smc_mem_model #(
  parameter int NV_BUSY = 200
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic lo_wr_in,
  input wire logic hi_wr_in,
  input wire logic lo_rd_in,
  input wire logic hi_rd_in,
  input wire smc_pkg::smc_dram_word_t wdata_in,
  input wire logic nv_strobe_in,
  input wire logic bad_hi_in,
  output smc_pkg::smc_dram_word_t rdata_out,
  output logic nv_ready_out
);
  smc_pkg::smc_dram_word_t mem_q;
  int busy_q;
  // ----------------------------------------------------------------
  // Word store and nonvolatile busy time
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_q <= '0;
      busy_q <= 0;
    end else begin
      if (lo_wr_in) begin
        mem_q[8:0] <= wdata_in[8:0];
      end
      if (hi_wr_in) begin
        mem_q[17:9] <= wdata_in[17:9];
      end
      if (nv_strobe_in) begin
        busy_q <= NV_BUSY;
      end else if (busy_q > 0) begin
        busy_q <= busy_q - 1;
      end
    end
  end
  assign nv_ready_out = (busy_q == 0);
  // Released lanes show the inverse of the stored value
  assign rdata_out[17:9] = hi_rd_in ?
    mem_q[17:9] ^ {bad_hi_in, 8'h00} : ~mem_q[17:9];
  assign rdata_out[8:0] = lo_rd_in ? mem_q[8:0] : ~mem_q[8:0];
endmodule

// ==== smc_pkg.sv ====
package smc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_COL_NS = 15;
  localparam int T_SIXTY_NS = 60;
  localparam int T_LATCH_NS = 120;
  localparam int T_READY_NS = 135;
  localparam int T_LATCH_END_NS = 165;
  localparam int T_HOST_ERR_NS = 195;
  localparam int T_END_NS = 225;
  localparam int REFRESH_PERIOD_NS = 12800;

  localparam logic [4:0] C_COL =
    5'((T_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] C_SIXTY =
    5'((T_SIXTY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] C_LATCH =
    5'((T_LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] C_READY =
    5'((T_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] C_LATCH_END =
    5'((T_LATCH_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] C_HOST_ERR =
    5'((T_HOST_ERR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] C_END =
    5'((T_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] C_REF_URGENT =
    10'(REFRESH_PERIOD_NS / 2 / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Decode and reset values
  // ----------------------------------------------------------------
  localparam logic [9:0] NV_GATE_PORT = 10'h162;
  localparam logic IOCHRDY_RST = 1'b1;

  // ----------------------------------------------------------------
  // Synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int SY_CPU = 0;
  localparam int SY_HOST = 1;
  localparam int SY_DMA = 2;
  localparam int SY_REF = 3;
  localparam int SY_MEMW = 4;
  localparam int SY_IOW = 5;
  localparam int SY_NVRDY = 6;
  localparam int SY_W = 7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SRC_CPU, SRC_HOST, SRC_DMA, SRC_REF} smc_src_t;

  typedef struct packed {
    logic par_hi;
    logic [7:0] hi;
    logic par_lo;
    logic [7:0] lo;
  } smc_dram_word_t;

  typedef struct packed {
    logic ok_hi;
    logic ok_lo;
  } smc_par_status_t;

endpackage

// ==== tb_shared_memory_cycle_checker.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_shared_memory_cycle_checker;
  typedef struct {
    logic [1:0] s;
    logic w;
    logic a0;
    logic [15:0] d;
  } smc_row_t;
  smc_row_t rows [9] = '{'{2'h0, 1'b1, 1'b0, 16'h1234},
    '{2'h1, 1'b1, 1'b1, 16'hAB00}, '{2'h1, 1'b1, 1'b0, 16'h00CD},
    '{2'h0, 1'b0, 1'b0, 16'hABCD}, '{2'h1, 1'b0, 1'b1, 16'hABCD},
    '{2'h1, 1'b0, 1'b0, 16'hABCD}, '{2'h2, 1'b1, 1'b0, 16'h5678},
    '{2'h2, 1'b0, 1'b0, 16'h5678}, '{2'h3, 1'b0, 1'b0, 16'h0000}};
  logic sys_clk_in, rstn_in, host_memw_in, host_iow_in, host_addr0_in;
  logic local_bus_write_flag_in, nvram_select_in, addr_decode_invalid_in;
  logic cpu_request_in, host_request_in, dma_request_in;
  logic refresh_request_in, nvram_ready_in, bad_hi;
  logic [3:0] req;
  logic [9:0] host_io_addr_in;
  logic [23:0] local_bus_addr_in, fault_address_capture_out;
  logic [15:0] local_bus_data_in, local_bus_read_data_out, rd;
  smc_pkg::smc_dram_word_t dram_rdata_in, dram_wdata_out;
  smc_pkg::smc_par_status_t parity_check_out, fault_status_capture_out, pc;
  logic [1:0] grant_out;
  logic cycle_timing_pulse_out, row_address_select_out, memory_done_out;
  logic bus_ready_strobe_out, io_latch_strobe_out, iochrdy_out, iochchk_out;
  logic host_lower_lane_enable_out, host_upper_lane_enable_out;
  logic host_transceiver_direction_out, lower_write_pulse_out;
  logic upper_write_pulse_out, lower_byte_write_enable_out;
  logic upper_byte_write_enable_out, nvram_write_strobe_out;
  logic cpu_parity_interrupt_out, address_outside_map_out;
  logic out_of_range_flag_out, range_fault_interrupt_out, nv_gate_armed_out;
  logic rr, pi, ia, rp;
  int num_errors = 0, checks = 0, cyc = 0;
  int kb, km, ki, ko, kn, nb, nn, nl;
  assign cpu_request_in = req[0];
  assign host_request_in = req[1];
  assign dma_request_in = req[2];
  assign refresh_request_in = req[3];

  smc_cycle_checker dut (.sys_clk_in, .rstn_in, .cpu_request_in,
    .host_request_in, .dma_request_in, .refresh_request_in, .host_memw_in,
    .host_iow_in, .host_io_addr_in, .host_addr0_in, .local_bus_write_flag_in,
    .nvram_select_in, .addr_decode_invalid_in, .local_bus_addr_in,
    .local_bus_data_in, .dram_rdata_in, .nvram_ready_in, .grant_out,
    .cycle_timing_pulse_out, .row_address_select_out, .bus_ready_strobe_out,
    .memory_done_out, .io_latch_strobe_out, .host_lower_lane_enable_out,
    .host_upper_lane_enable_out, .host_transceiver_direction_out,
    .lower_write_pulse_out, .upper_write_pulse_out,
    .lower_byte_write_enable_out, .upper_byte_write_enable_out,
    .nvram_write_strobe_out, .dram_wdata_out, .local_bus_read_data_out,
    .parity_check_out, .cpu_parity_interrupt_out, .fault_address_capture_out,
    .fault_status_capture_out, .iochrdy_out, .iochchk_out,
    .address_outside_map_out, .out_of_range_flag_out,
    .range_fault_interrupt_out, .nv_gate_armed_out);

  smc_mem_model mem (.clk_in(sys_clk_in), .rstn_in(rstn_in),
    .lo_wr_in(lower_write_pulse_out), .hi_wr_in(upper_write_pulse_out),
    .lo_rd_in(lower_byte_write_enable_out),
    .hi_rd_in(upper_byte_write_enable_out), .wdata_in(dram_wdata_out),
    .nv_strobe_in(nvram_write_strobe_out), .bad_hi_in(bad_hi),
    .rdata_out(dram_rdata_in), .nv_ready_out(nvram_ready_in));

  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk_in);
    #2;
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // One memory cycle, timed from the first clock of the timing pulse
  // ----------------------------------------------------------------
  task automatic run(input logic [1:0] s, input logic w, a0, nv, inv,
                     input logic [15:0] d);
    logic hs, rf;
    int k;
    hs = (s == 2'h1);
    rf = (s == 2'h3);
    local_bus_write_flag_in = w;
    host_addr0_in = a0;
    nvram_select_in = nv;
    addr_decode_invalid_in = inv;
    local_bus_data_in = d;
    req[s] = 1'b1;
    k = 0;
    while (cycle_timing_pulse_out !== 1'b1 && k < 60) begin
      clk(1);
      k++;
    end
    `CHK(grant_out, s)
    kb = -1;
    km = -1;
    ki = -1;
    ko = -1;
    kn = -1;
    {nb, nn, nl, rr, pi, rp} = '0;
    for (k = 0; k < 31; k++) begin
      if (k == 4) begin
        `CHK(host_upper_lane_enable_out, hs && a0)
        `CHK(host_lower_lane_enable_out, hs && !a0)
        `CHK(host_transceiver_direction_out, hs && !w)
        `CHK(upper_byte_write_enable_out, !w && !nv && !rf)
        `CHK(lower_byte_write_enable_out, !w && !nv && !rf)
        if (!nv) `CHK(upper_write_pulse_out, w && !rf && (!hs || a0))
        if (!nv) `CHK(lower_write_pulse_out, w && !rf && (!hs || !a0))
        if (w) `CHK(dram_wdata_out, {^d[15:8], d[15:8], ^d[7:0], d[7:0]})
        if (hs) `CHK(iochrdy_out, 1'b0)
      end
      if (k == 1) `CHK(row_address_select_out, 1'b1)
      if (k == 2) `CHK(row_address_select_out, 1'b0)
      if (k == 16) `CHK(cycle_timing_pulse_out, 1'b1)
      if (k == 16) begin
        rd = local_bus_read_data_out;
        pc = parity_check_out;
      end
      if (k == 18) ia = address_outside_map_out;
      if (bus_ready_strobe_out === 1'b1 && kb < 0) kb = k;
      if (memory_done_out === 1'b1 && km < 0) km = k;
      if (address_outside_map_out === 1'b1 && ki < 0) ki = k;
      if (out_of_range_flag_out === 1'b1 && ko < 0) ko = k;
      if (nvram_write_strobe_out === 1'b1 && kn < 0) kn = k;
      if (range_fault_interrupt_out === 1'b1 && rp !== 1'b1) rr = 1'b1;
      if (cpu_parity_interrupt_out === 1'b1) pi = 1'b1;
      rp = range_fault_interrupt_out;
      nb += (bus_ready_strobe_out === 1'b1);
      nn += (nvram_write_strobe_out === 1'b1);
      nl += (io_latch_strobe_out === 1'b1);
      clk(1);
    end
    `CHK(kb, 17)
    `CHK(km - kb, 3)
    `CHK(nb, 12)
    if (s == 2'h2) `CHK(nl, 6)
    if (hs) `CHK(iochrdy_out, 1'b1)
    req[s] = 1'b0;
    clk(5);
  endtask

  task automatic iow(input logic [9:0] a);
    host_io_addr_in = a;
    host_iow_in = 1'b1;
    clk(4);
    host_iow_in = 1'b0;
    clk(6);
  endtask

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    {rstn_in, host_memw_in, host_iow_in, host_addr0_in, bad_hi} = '0;
    {local_bus_write_flag_in, nvram_select_in, addr_decode_invalid_in} = '0;
    req = 4'h0;
    host_io_addr_in = 10'h000;
    local_bus_addr_in = 24'h012345;
    local_bus_data_in = 16'h0000;
    clk(12);
    rstn_in = 1'b1;
    `CHK(iochrdy_out, 1'b1)
    clk(2);
    foreach (rows[i]) begin
      run(rows[i].s, rows[i].w, rows[i].a0, 1'b0, 1'b0, rows[i].d);
      if (!rows[i].w && rows[i].s != 2'h3) `CHK(rd, rows[i].d)
    end
    bad_hi = 1'b1;
    run(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
    `CHK(pi, 1'b1)
    `CHK(pc, 2'h1)
    `CHK(fault_address_capture_out, 24'h012345)
    `CHK(fault_status_capture_out, 2'h1)
    run(2'h1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
    `CHK(iochchk_out, 1'b1)
    bad_hi = 1'b0;
    host_memw_in = 1'b1;
    clk(8);
    host_memw_in = 1'b0;
    `CHK(iochchk_out, 1'b0)
    run(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
    `CHK(ki, 9)
    `CHK(ko, 10)
    `CHK(rr, 1'b1)
    `CHK(ia, 1'b0)
    run(2'h3, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
    `CHK(rr, 1'b0)
    run(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h00A5);
    `CHK(rd, 16'h80A5)
    run(2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 16'h005A);
    `CHK(kn, 8)
    `CHK(nn, 9)
    run(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h00A5);
    `CHK(rd, 16'h00A5)
    clk(250);
    run(2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 16'h005A);
    `CHK(nn, 0)
    iow(10'h163);
    `CHK(nv_gate_armed_out, 1'b0)
    iow(10'h162);
    `CHK(nv_gate_armed_out, 1'b1)
    run(2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 16'h005A);
    `CHK(nn, 9)
    `CHK(nv_gate_armed_out, 1'b0)
    clk(40);
    `CHK(cycle_timing_pulse_out, 1'b0)
    print_verdict();
  end
endmodule
